// ===== rtl/ep_dma_pkg.sv
`default_nettype none
package ep_dma_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int DATA_W = 8;
   localparam int ADDR_W = 32;
   localparam int SIZE_W = 16;
   localparam int BUF_W = DATA_W + 1;
   // packet-end flag sits above the data byte in a buffer word
   localparam int BUF_PKT_END = DATA_W;

   // ****************************************
   // sizes and reset values
   // ****************************************
   localparam logic [SIZE_W-1:0] MAX_PKT_BYTES = 16'h0200;
   localparam logic [SIZE_W-1:0] SIZE_RST = 16'h0200;
   localparam logic [SIZE_W-1:0] SIZE_ZERO = 16'h0000;
   localparam logic [SIZE_W-1:0] SIZE_ONE = 16'h0001;
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0001;

   // ****************************************
   // two-entry buffer fill levels
   // ****************************************
   localparam logic [1:0] BUF_EMPTY = 2'h0;
   localparam logic [1:0] BUF_ONE = 2'h1;
   localparam logic [1:0] BUF_FULL = 2'h2;

   // ****************************************
   // modes and states
   // ****************************************
   typedef enum logic {
      MODE_SIZE_AGG = 1'b0,
      MODE_PER_PKT = 1'b1
   } dma_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_DRAIN = 2'b11,
      ST_DONE = 2'b10
   } dma_state_t;
endpackage
`default_nettype wire

// ===== rtl/two_entry_buf.sv
`default_nettype none
module two_entry_buf
   import ep_dma_pkg::*;
#(
   parameter int WIDTH = BUF_W
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   // ****************************************
   // head word drives the output straight from a flop
   // ****************************************
   logic [WIDTH-1:0] head_ff, nxt_head;
   logic [WIDTH-1:0] spare_ff, nxt_spare;
   logic [1:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign in_ready = (cnt_ff != BUF_FULL);
   assign out_valid = (cnt_ff != BUF_EMPTY);
   assign out_data = head_ff;

   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      nxt_head = head_ff;
      nxt_spare = spare_ff;
      nxt_cnt = cnt_ff;
      case (cnt_ff)
         BUF_EMPTY: begin
            if (push) begin
               nxt_head = in_data;
               nxt_cnt = BUF_ONE;
            end
         end
         BUF_ONE: begin
            if (push && pop) begin
               nxt_head = in_data;
            end else if (push) begin
               nxt_spare = in_data;
               nxt_cnt = BUF_FULL;
            end else if (pop) begin
               nxt_cnt = BUF_EMPTY;
            end
         end
         BUF_FULL: begin
            // full refuses input, so only a pop can happen here
            if (pop) begin
               nxt_head = spare_ff;
               nxt_cnt = BUF_ONE;
            end
         end
         default: begin
            nxt_cnt = BUF_EMPTY;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         head_ff <= '0;
         spare_ff <= '0;
         cnt_ff <= BUF_EMPTY;
      end else begin
         head_ff <= nxt_head;
         spare_ff <= nxt_spare;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/ep_dma.sv
// Operation
// - no host byte is accepted until software has configured and started the DMA
// - size-aggregated mode treats up to the programmed byte count as one transfer
// - with room in the endpoint buffer, host data is taken and moved to memory
// - a running transfer uses the size, mode and base latched at its start
// - size-aggregated mode gives one interrupt per whole transfer, none per packet
// - per-packet mode gives one interrupt for every packet written to memory
// - isochronous endpoints interrupt per packet; transfer size equals packet size
// - no coalescing of isochronous interrupts is offered
`default_nettype none
module ep_dma
   import ep_dma_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic mode_sel,
   input wire logic iso_en,
   input wire logic [SIZE_W-1:0] xfer_size,
   input wire logic [ADDR_W-1:0] mem_base,
   input wire logic dma_start,
   input wire logic dma_stop,
   input wire logic [DATA_W-1:0] host_data,
   input wire logic host_valid,
   input wire logic host_last,
   output logic host_ready,
   output logic [DATA_W-1:0] mem_data,
   output logic [ADDR_W-1:0] mem_addr,
   output logic mem_valid,
   input wire logic mem_ready,
   output logic xfer_irq,
   output logic pkt_irq,
   output logic dma_idle,
   output logic [SIZE_W-1:0] bytes_done
);
   // ****************************************
   // declarations
   // ****************************************
   dma_state_t state_ff, nxt_state;
   dma_mode_t mode_ff, nxt_mode;
   logic iso_ff, nxt_iso;
   logic [SIZE_W-1:0] size_ff, nxt_size;
   logic [SIZE_W-1:0] cnt_in_ff, nxt_cnt_in;
   logic [SIZE_W-1:0] pkt_cnt_ff, nxt_pkt_cnt;
   logic [SIZE_W-1:0] cnt_out_ff, nxt_cnt_out;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic in_pkt_ff, nxt_in_pkt;
   logic xfer_irq_ff, nxt_xfer_irq;
   logic pkt_irq_ff, nxt_pkt_irq;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [BUF_W-1:0] buf_out_data;
   logic [BUF_W-1:0] buf_in_data;
   logic take;
   logic put;
   logic agg_active;
   logic size_hit;
   logic short_pkt;
   logic agg_end;
   logic start_ok;

   // ****************************************
   // endpoint buffer between host and memory
   // ****************************************
   assign buf_in_data = {host_last, host_data};

   two_entry_buf #(
      .WIDTH(BUF_W)
   ) u_buf (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .in_data(buf_in_data),
      .in_valid(host_valid && (state_ff == ST_RUN)),
      .in_ready(buf_in_ready),
      .out_data(buf_out_data),
      .out_valid(buf_out_valid),
      .out_ready(mem_ready)
   );

   // host is held off unless a configured transfer is running
   assign host_ready = buf_in_ready && (state_ff == ST_RUN);
   assign take = host_valid && host_ready;
   assign put = buf_out_valid && mem_ready;

   assign mem_valid = buf_out_valid;
   assign mem_data = buf_out_data[DATA_W-1:0];
   assign mem_addr = addr_ff;
   assign xfer_irq = xfer_irq_ff;
   assign pkt_irq = pkt_irq_ff;
   assign dma_idle = (state_ff == ST_IDLE);
   assign bytes_done = cnt_out_ff;

   // ****************************************
   // transfer end detection
   // ****************************************
   // isochronous endpoints never aggregate: size equals packet size
   assign agg_active = (mode_ff == MODE_SIZE_AGG) && !iso_ff;
   assign size_hit = ((cnt_in_ff + SIZE_ONE) == size_ff);
   // a short packet also closes an aggregated transfer early
   assign short_pkt = host_last && ((pkt_cnt_ff + SIZE_ONE) < MAX_PKT_BYTES);
   assign agg_end = take && agg_active && (size_hit || short_pkt);
   // zero size cannot end an aggregated transfer on a count, so it is not started
   assign start_ok = dma_start && ((mode_sel == MODE_PER_PKT) || iso_en ||
                                   (xfer_size != SIZE_ZERO));

   // ****************************************
   // control state
   // ****************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_mode = mode_ff;
      nxt_iso = iso_ff;
      nxt_size = size_ff;
      nxt_cnt_in = cnt_in_ff;
      nxt_pkt_cnt = pkt_cnt_ff;
      nxt_cnt_out = cnt_out_ff;
      nxt_addr = addr_ff;
      nxt_in_pkt = in_pkt_ff;
      nxt_xfer_irq = 1'b0;
      nxt_pkt_irq = 1'b0;
      if (take) begin
         nxt_cnt_in = cnt_in_ff + SIZE_ONE;
         nxt_pkt_cnt = host_last ? SIZE_ZERO : (pkt_cnt_ff + SIZE_ONE);
         nxt_in_pkt = !host_last;
      end
      if (put) begin
         nxt_addr = addr_ff + ADDR_STEP;
         nxt_cnt_out = cnt_out_ff + SIZE_ONE;
         // one pulse per packet when not aggregating, no batching option exists
         nxt_pkt_irq = buf_out_data[BUF_PKT_END] && !agg_active;
      end
      case (state_ff)
         ST_IDLE: begin
            // parameters are sampled only here; later changes are ignored
            if (start_ok) begin
               nxt_mode = dma_mode_t'(mode_sel);
               nxt_iso = iso_en;
               nxt_size = xfer_size;
               nxt_addr = mem_base;
               nxt_cnt_in = SIZE_ZERO;
               nxt_cnt_out = SIZE_ZERO;
               nxt_pkt_cnt = SIZE_ZERO;
               nxt_in_pkt = 1'b0;
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            // stop only between packets so no packet is cut in half
            if (agg_end) begin
               nxt_state = ST_DRAIN;
            end else if (!agg_active && dma_stop && !in_pkt_ff && !take) begin
               nxt_state = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // nothing enters now, so an empty buffer means all bytes are in memory
            if (!buf_out_valid) begin
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            nxt_xfer_irq = agg_active;
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
         mode_ff <= MODE_SIZE_AGG;
         iso_ff <= 1'b0;
         size_ff <= SIZE_RST;
         cnt_in_ff <= SIZE_ZERO;
         pkt_cnt_ff <= SIZE_ZERO;
         cnt_out_ff <= SIZE_ZERO;
         addr_ff <= ADDR_RST;
         in_pkt_ff <= 1'b0;
         xfer_irq_ff <= 1'b0;
         pkt_irq_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         mode_ff <= nxt_mode;
         iso_ff <= nxt_iso;
         size_ff <= nxt_size;
         cnt_in_ff <= nxt_cnt_in;
         pkt_cnt_ff <= nxt_pkt_cnt;
         cnt_out_ff <= nxt_cnt_out;
         addr_ff <= nxt_addr;
         in_pkt_ff <= nxt_in_pkt;
         xfer_irq_ff <= nxt_xfer_irq;
         pkt_irq_ff <= nxt_pkt_irq;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   chk_hold_off_host: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state_ff != ST_RUN) |-> !host_ready)
      else $error("host data accepted while dma not running");

   chk_start_opens: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state_ff == ST_IDLE && start_ok) |=> (state_ff == ST_RUN) && (host_ready == buf_in_ready))
      else $error("started dma does not accept host data");

   chk_size_frozen: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state_ff != ST_IDLE && $past(state_ff) != ST_IDLE) |-> $stable(size_ff) && $stable(mode_ff))
      else $error("transfer parameters changed mid transfer");

   chk_count_bound: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state_ff != ST_IDLE && agg_active) |-> (cnt_in_ff <= size_ff))
      else $error("aggregated transfer passed its size");

   chk_size_closes: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (take && agg_active && size_hit) |=> (state_ff == ST_DRAIN) && !host_ready)
      else $error("transfer did not close at programmed size");

   chk_agg_single_irq: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      agg_active |-> !pkt_irq)
      else $error("packet interrupt in size aggregated mode");

   chk_irq_one_pulse: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      xfer_irq |=> !xfer_irq [*3])
      else $error("completion interrupt repeated");

   chk_pkt_irq_each: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (put && buf_out_data[BUF_PKT_END] && mode_ff == MODE_PER_PKT) |=> pkt_irq)
      else $error("missing per packet interrupt");

   chk_iso_irq_each: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (put && iso_ff && state_ff != ST_IDLE) |=> (pkt_irq == $past(buf_out_data[BUF_PKT_END])))
      else $error("isochronous interrupt not per packet");

   chk_drain_finish: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state_ff == ST_DRAIN && !buf_out_valid) |=> (state_ff == ST_DONE) ##1 dma_idle)
      else $error("dma did not return to idle after completion");

   chk_irq_then_idle: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      $rose(xfer_irq) |-> dma_idle && !host_ready)
      else $error("completion signalled while dma still busy");

   chk_short_closes: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (take && agg_active && short_pkt) |=> (state_ff == ST_DRAIN) && !host_ready)
      else $error("short packet did not close aggregated transfer");

   chk_run_holds: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state_ff == ST_RUN && !agg_active && !dma_stop) |=> (state_ff == ST_RUN))
      else $error("per packet run ended without stop");

   chk_pkt_whole: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state_ff == ST_RUN && !agg_active && in_pkt_ff) |=> (state_ff == ST_RUN))
      else $error("per packet run cut inside a packet");

   chk_done_irq: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state_ff == ST_DONE && agg_active) |=> xfer_irq)
      else $error("aggregated transfer ended without interrupt");

   chk_done_quiet: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state_ff == ST_DONE && !agg_active) |=> !xfer_irq)
      else $error("transfer interrupt outside aggregated mode");

   chk_pkt_irq_cause: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      pkt_irq |-> $past(put) && $past(buf_out_data[BUF_PKT_END]))
      else $error("packet interrupt without a packet end");

   chk_addr_step: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      put |=> (mem_addr == ($past(mem_addr) + ADDR_STEP)))
      else $error("memory address did not step by one");

   chk_count_step: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      put |=> (bytes_done == ($past(bytes_done) + SIZE_ONE)))
      else $error("byte count did not follow memory writes");

   chk_idle_quiet: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      dma_idle |-> !mem_valid && !host_ready)
      else $error("idle dma still moving data");
endmodule
`default_nettype wire

// ===== sim/usb_host_model.sv
`default_nettype none
// ********************
// host byte source
// ********************
module usb_host_model
   import ep_dma_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [SIZE_W-1:0] pkt_len,
   input wire logic pkt_go,
   input wire logic host_ready,
   output logic [DATA_W-1:0] host_data,
   output logic host_valid,
   output logic host_last,
   output logic pkt_busy
);
   timeunit 1ns;
   timeprecision 100ps;
   int left;
   logic [DATA_W-1:0] seed;
   logic hs;
   assign hs = host_valid && host_ready;
   assign pkt_busy = host_valid || (left != 0);
   // packets only on command, after the dma is started
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         left = 0;
         seed = 8'h3c;
         host_valid <= 1'b0;
         host_last <= 1'b0;
         host_data <= 8'h00;
      end else begin
         if (hs) begin
            left = left - 1;
            seed = seed + 8'h01;
         end
         if (pkt_go && !pkt_busy) begin
            left = int'(pkt_len);
         end
         // a byte stands until taken; released line toggles, no stale byte
         if (hs || !host_valid) begin
            host_valid <= (left != 0);
            host_last <= (left == 1);
            host_data <= (left != 0) ? seed : ~host_data;
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/usb_endpoint_dma_modes_tb.sv
`default_nettype none
module usb_endpoint_dma_modes_tb
   import ep_dma_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ********************
   // bench signals
   // ********************
   logic sys_clk, rstn, mode_sel, iso_en, dma_start, dma_stop, host_valid, host_last;
   logic host_ready, mem_valid, mem_ready, xfer_irq, pkt_irq, dma_idle, pkt_go, pkt_busy;
   logic stall;
   logic [SIZE_W-1:0] xfer_size, bytes_done, pkt_len;
   logic [ADDR_W-1:0] mem_base, mem_addr, exp_addr;
   logic [DATA_W-1:0] host_data, mem_data;
   logic [DATA_W-1:0] exp_q[$];
   int failures, cmp_count, n_byte, n_pkt, n_x;

   ep_dma i_dut (.sys_clk(sys_clk), .rstn(rstn), .mode_sel(mode_sel), .iso_en(iso_en),
      .xfer_size(xfer_size), .mem_base(mem_base), .dma_start(dma_start), .dma_stop(dma_stop),
      .host_data(host_data), .host_valid(host_valid), .host_last(host_last),
      .host_ready(host_ready), .mem_data(mem_data), .mem_addr(mem_addr),
      .mem_valid(mem_valid), .mem_ready(mem_ready), .xfer_irq(xfer_irq), .pkt_irq(pkt_irq),
      .dma_idle(dma_idle), .bytes_done(bytes_done));
   usb_host_model i_host (.sys_clk(sys_clk), .rstn(rstn), .pkt_len(pkt_len), .pkt_go(pkt_go),
      .host_ready(host_ready), .host_data(host_data), .host_valid(host_valid),
      .host_last(host_last), .pkt_busy(pkt_busy));

   task automatic chk(input bit ok, input string msg);
      cmp_count++;
      if (!ok) begin
         failures++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic wait_idle(input logic v);
      int i;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (dma_idle !== v && i < 2000);
      chk(dma_idle === v, "idle level wrong");
   endtask

   // model: byte order, addresses and interrupt counts
   always @(posedge sys_clk) begin
      if (rstn) begin
         if (host_valid && host_ready) exp_q.push_back(host_data);
         if (mem_valid && mem_ready) begin
            chk(exp_q.size() > 0 && mem_data === exp_q[0] && mem_addr === exp_addr,
               "memory write wrong");
            if (exp_q.size() > 0) void'(exp_q.pop_front());
            exp_addr = exp_addr + ADDR_STEP;
            n_byte++;
         end
         n_pkt += int'(pkt_irq === 1'b1);
         n_x += int'(xfer_irq === 1'b1);
      end
      mem_ready <= !stall && ($urandom_range(3) != 0);
   end

   task automatic run(input string nm, input logic m, input logic iso, input int size,
         input int plen, input int npkt, input bit stl);
      bit agg;
      int eb;
      agg = (m == MODE_SIZE_AGG) && !iso;
      eb = (agg && size < plen) ? size : plen * npkt;
      n_byte = 0;
      n_pkt = 0;
      n_x = 0;
      stall <= stl;
      exp_addr = $urandom;
      mem_base <= exp_addr;
      mode_sel <= m;
      iso_en <= iso;
      xfer_size <= size[SIZE_W-1:0];
      dma_start <= 1'b1;
      @(posedge sys_clk);
      dma_start <= 1'b0;
      // configuration stands unchanged until the transfer is over
      wait_idle(1'b0);
      for (int p = 0; p < npkt; p++) begin
         pkt_len <= plen[SIZE_W-1:0];
         pkt_go <= 1'b1;
         @(posedge sys_clk);
         pkt_go <= 1'b0;
         // host model loaded the packet at the edge above, so busy is already set before this one
         @(posedge sys_clk);
         if (stl) begin
            repeat (8) @(posedge sys_clk);
            chk(host_ready === 1'b0 && mem_valid === 1'b1, "full buffer not refusing");
            stall <= 1'b0;
         end
         for (int i = 0; i < 4000 && pkt_busy; i++) @(posedge sys_clk);
         // idle gap between packets and transfers
         repeat (3) @(posedge sys_clk);
      end
      if (!agg) begin
         dma_stop <= 1'b1;
         @(posedge sys_clk);
         dma_stop <= 1'b0;
      end
      wait_idle(1'b1);
      repeat (2) @(posedge sys_clk);
      chk(n_byte == eb && exp_q.size() == 0, "byte count wrong");
      chk(bytes_done === eb[SIZE_W-1:0], "bytes done wrong");
      chk(n_pkt == (agg ? 0 : npkt), "packet interrupts wrong");
      chk(n_x == (agg ? 1 : 0), "transfer interrupts wrong");
      $display("test %s done", nm);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      give_verdict();
   end

   initial begin
      failures = 0;
      cmp_count = 0;
      void'($urandom(37));
      {rstn, mode_sel, iso_en, dma_start, dma_stop, pkt_go} = '0;
      stall = 1'b0;
      xfer_size = SIZE_RST;
      mem_base = ADDR_RST;
      pkt_len = SIZE_ONE;
      exp_addr = ADDR_RST;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      chk(host_ready === 1'b0 && dma_idle === 1'b1, "ready before start");
      chk(mem_addr === ADDR_RST && bytes_done === SIZE_ZERO, "reset values wrong");
      chk(mem_valid === 1'b0 && xfer_irq === 1'b0, "reset outputs wrong");
      xfer_size <= SIZE_ZERO;
      dma_start <= 1'b1;
      @(posedge sys_clk);
      dma_start <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(dma_idle === 1'b1 && host_ready === 1'b0, "zero size started");
      $display("test zero_size done");
      run("agg_stall", MODE_SIZE_AGG, 1'b0, 5, 5, 1, 1'b1);
      run("agg_short", MODE_SIZE_AGG, 1'b0, 20, 7, 1, 1'b0);
      run("agg_full", MODE_SIZE_AGG, 1'b0, 512, 512, 1, 1'b0);
      run("per_pkt", MODE_PER_PKT, 1'b0, 9, 1, 3, 1'b0);
      run("iso", MODE_SIZE_AGG, 1'b1, 1, 4, 2, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
